// File: arbitration_pin_port.sv
// Port logic reusing spare arbitration request and grant pins as general purpose pins
//
// Overview of operation
// (R1) Bit 18 gives fourth grant/request pins to port
// (R2) Bit 17 gives third grant/request pins to port
// (R3) Bit 16 gives second grant/request pins to port
// (R4) No port function in host arbitration mode
// (R5) Pull-up bits 5,3,1: zero enables pull-up
// (R6) Direction bits 4,2,0: one makes output
// (R7) Control register cleared only at power-on
// (R8) Data register cleared only at power-on
// (R9) Reserved bits read zero, write zero
// (R10) Pins driven and sampled on bus clock
// (R11) Data bits 5,3,1 drive grant pins
// (R12) Data bits 4,2,0 serve request pins
// (R13) Both registers 32-bit, peripheral bus only
// (R14) Host mode latched at power-on release
// (R15) Input read returns sampled pin level
// (R16) Disabled pair leaves pins to arbiter
`timescale 1ns/1ps
`include "arbitration_pin_port_params.svh"
`default_nettype none
module arbitration_pin_port
	import arbitration_pin_port_pkg::*;
#(
	parameter int PAIRS = `APP_PAIRS // Number of pin pairs
)(
	// Clock and power-on reset
	input  wire logic              mclk_i,
	input  wire logic              resetn_i,
	// Mode strap and arbiter state
	input  wire logic              host_mode_pin_i,
	input  wire logic              arb_enable_i,
	// Peripheral bus
	input  wire pbus_req_t         pbus_req_i,
	output logic [31:0]            pbus_rdata_o,
	// Arbiter pin levels when pair is not a port
	input  wire logic [PAIRS-1:0]  arb_grant_i,
	// Request pin inputs, pair 0 = second request pin
	input  wire logic [PAIRS-1:0]  request_pin_i,
	// Pin drive
	output logic [PAIRS-1:0]       grant_pin_o,
	output logic [PAIRS-1:0]       grant_pin_oe_o,
	output logic [PAIRS-1:0]       request_pin_o,
	output logic [PAIRS-1:0]       request_pin_oe_o,
	output logic [PAIRS-1:0]       request_pullup_o,
	// Pairs handed to port logic
	output logic [PAIRS-1:0]       port_owned_o
);
	// Register fields exist for three pairs only
	if (PAIRS != 3)
	begin : g_bad_pairs
		$error("arbitration_pin_port supports exactly three pairs");
	end

	logic [31:0]      ctrl_q;        // Port function control
	logic [31:0]      data_q;        // Port pin data latch
	logic [PAIRS-1:0] req_meta_q;    // First synchroniser stage
	logic [PAIRS-1:0] req_sync_q;    // Second stage, sampled level
	logic             strap_meta_q;  // Strap synchroniser
	logic             strap_sync_q;
	logic             strap_taken_q; // Strap caught once
	logic [1:0]       strap_age_q;   // Edges since release, fills with ones
	logic             non_host_q;    // Latched non-host mode
	logic [PAIRS-1:0] owned;         // Effective port ownership
	logic [31:0]      data_view;     // Data as read back
	pair_drive_t      drv [PAIRS];   // Per-pair drive

	wire wr_ctrl = pbus_req_i.sel && pbus_req_i.wr && (pbus_req_i.addr == `APP_CTRL_OFFSET);
	wire wr_data = pbus_req_i.sel && pbus_req_i.wr && (pbus_req_i.addr == `APP_DATA_OFFSET);

	// Strap synchroniser; the level is captured after reset release, never under reset
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
		end
		else
		begin
			strap_meta_q <= host_mode_pin_i;
			strap_sync_q <= strap_meta_q;
		end
	end

	// Mode latched once after power-on release and held until next reset;
	// waits two edges so the second stage holds the strap, not its reset value
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_age_q   <= 2'b00;
			strap_taken_q <= 1'b0;
			non_host_q    <= 1'b0;
		end
		else
		begin
			strap_age_q <= {strap_age_q[0], 1'b1};
			// Third edge after release: synchroniser now carries the pin level
			if (strap_age_q[1] && !strap_taken_q)
			begin
				strap_taken_q <= 1'b1; // R14
				non_host_q    <= strap_sync_q; // R14
			end
		end
	end

	// Control register: power-on reset only, reserved bits never stored
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_q <= `APP_CTRL_RESET; // R7
		else if (wr_ctrl)
			ctrl_q <= pbus_req_i.wdata & `APP_CTRL_MASK; // R9 R13
	end

	// Data register: power-on reset only
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			data_q <= `APP_DATA_RESET; // R8
		else if (wr_data)
			data_q <= pbus_req_i.wdata & `APP_DATA_MASK; // R9 R13
	end

	// Request pin input sampling on the bus clock rising edge
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			req_meta_q <= '0;
			req_sync_q <= '0;
		end
		else
		begin
			req_meta_q <= request_pin_i; // R10
			req_sync_q <= req_meta_q;
		end
	end

	// Per-pair pin steering
	genvar g;
	generate
		for (g = 0; g < PAIRS; g++)
		begin : g_pair
			// Host with arbitration never owns the pins, whatever the enable
			assign owned[g] = ctrl_q[`APP_CTRL_EN_LSB + g] && (non_host_q || !arb_enable_i); // R1 R2 R3 R4
			always_comb
			begin
				drv[g].grant_out   = owned[g] ? data_q[2*g+1] : arb_grant_i[g]; // R11 R16
				drv[g].grant_oe    = owned[g];
				drv[g].request_out = data_q[2*g]; // R12
				drv[g].request_oe  = owned[g] && ctrl_q[2*g]; // R6 R16
				drv[g].request_pu  = owned[g] && !ctrl_q[2*g+1]; // R5
			end
			// Input pins read the sample, output pins the written value
			assign data_view[2*g]   = (owned[g] && !ctrl_q[2*g]) ? req_sync_q[g] : data_q[2*g]; // R15
			assign data_view[2*g+1] = data_q[2*g+1];
		end
	endgenerate
	assign data_view[31:2*PAIRS] = '0; // R9

	// Registered pin drive so levels change on the bus clock
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			grant_pin_o      <= '0;
			grant_pin_oe_o   <= '0;
			request_pin_o    <= '0;
			request_pin_oe_o <= '0;
			request_pullup_o <= '0;
			port_owned_o     <= '0;
		end
		else
		begin
			for (int i = 0; i < PAIRS; i++)
			begin
				grant_pin_o[i]      <= drv[i].grant_out; // R10
				grant_pin_oe_o[i]   <= drv[i].grant_oe;
				request_pin_o[i]    <= drv[i].request_out;
				request_pin_oe_o[i] <= drv[i].request_oe;
				request_pullup_o[i] <= drv[i].request_pu;
			end
			port_owned_o <= owned;
		end
	end

	// Registered read data; unmapped offsets read zero
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pbus_rdata_o <= '0;
		else if (pbus_req_i.sel && !pbus_req_i.wr)
		begin
			case (pbus_req_i.addr)
				`APP_CTRL_OFFSET: pbus_rdata_o <= ctrl_q; // R9
				`APP_DATA_OFFSET: pbus_rdata_o <= data_view; // R15
				default:          pbus_rdata_o <= '0;
			endcase
		end
	end

	// Reserved control bits never read back
	AST_CTRL_RESERVED: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(ctrl_q & ~`APP_CTRL_MASK) == 32'h0) else $error("reserved control bits set"); // R9
	// Disabled first pair (enable bit 16) never drives its grant pin
	AST_DISABLED_GRANT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!ctrl_q[`APP_CTRL_EN_LSB] |=> !grant_pin_oe_o[0]) else $error("disabled pair drives grant"); // R3 R16
	// Output direction drives request pin next cycle
	AST_REQ_DIR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(owned[1] && ctrl_q[2]) |=> request_pin_oe_o[1]) else $error("request pin not driven"); // R6 R2
	// Pull-up follows control bit
	AST_PULLUP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(owned[2] && ctrl_q[5]) |=> !request_pullup_o[2]) else $error("pull-up not off"); // R5 R1
	// Grant level follows data bit when owned
	AST_GRANT_DATA: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		owned[2] |=> grant_pin_o[2] == $past(data_q[5])) else $error("grant level wrong"); // R11
	// Host with arbitration never owns pins
	AST_HOST_BLOCK: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(strap_taken_q && !non_host_q && arb_enable_i) |-> owned == '0) else $error("port in host mode"); // R4
	// Mode never changes once latched
	AST_MODE_HOLD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		strap_taken_q |=> $stable(non_host_q)) else $error("mode changed"); // R14
	// Data write lands masked
	AST_DATA_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_data |=> data_q == ($past(pbus_req_i.wdata) & `APP_DATA_MASK)) else $error("data write lost"); // R8 R12
endmodule : arbitration_pin_port
`default_nettype wire

// File: arbitration_pin_port_params.svh
// Register offsets, field positions, reset values and timing for the arbitration pin port
`ifndef ARBITRATION_PIN_PORT_PARAMS_SVH
`define ARBITRATION_PIN_PORT_PARAMS_SVH
`define APP_CTRL_OFFSET      8'h00
`define APP_DATA_OFFSET      8'h04
`define APP_CTRL_RESET       32'h00000000
`define APP_DATA_RESET       32'h00000000
`define APP_CTRL_EN_LSB      16
`define APP_CTRL_MASK        32'h0007003f
`define APP_DATA_MASK        32'h0000003f
`define APP_PAIRS            3
`define APP_CLK_PERIOD_NS    25
`endif

// File: arbitration_pin_port_pkg.sv
// Types shared by the arbitration pin port
`default_nettype none
package arbitration_pin_port_pkg;
	// Per-pair pin drive bundle
	typedef struct packed {
		logic grant_out;     // Level for grant pin
		logic grant_oe;      // Grant pin driven by port
		logic request_out;   // Level for request pin
		logic request_oe;    // Request pin driven by port
		logic request_pu;    // Pull-up enable on request pin
	} pair_drive_t;
	// Peripheral bus request
	typedef struct packed {
		logic        sel;    // Access strobe
		logic        wr;     // Write when set
		logic [7:0]  addr;   // Byte offset
		logic [31:0] wdata;  // Write data
	} pbus_req_t;
endpackage : arbitration_pin_port_pkg
`default_nettype wire

// File: req_pin_partner.sv
// Model of the request pin lines outside the device
`timescale 1ns/1ps
`default_nettype none
module req_pin_partner #(
	parameter int PAIRS = 3 // Number of pin pairs
)(
	// Clock
	input  wire logic             mclk_i,
	// Device drive and pull-up
	input  wire logic [PAIRS-1:0] dev_out_i,
	input  wire logic [PAIRS-1:0] dev_oe_i,
	input  wire logic [PAIRS-1:0] pullup_i,
	// External driver set by the bench
	input  wire logic [PAIRS-1:0] ext_oe_i,
	input  wire logic [PAIRS-1:0] ext_val_i,
	// Resolved line level
	output logic [PAIRS-1:0]      wire_o
);
	logic [PAIRS-1:0] float_q = '0; // Undriven lines wander so a stale level never passes
	// Toggle the floating level every cycle
	always_ff @(posedge mclk_i)
	begin
		float_q <= ~float_q;
	end
	// Device drive wins, then the external driver, then the pull-up
	assign wire_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_oe_i & ext_val_i)
		| (~dev_oe_i & ~ext_oe_i & (pullup_i | float_q));
endmodule : req_pin_partner
`default_nettype wire

// File: test_arbitration_pin_port.sv
// Self-checking bench for the arbitration pin port
`timescale 1ns/1ps
`default_nettype none
module test_arbitration_pin_port;
	import arbitration_pin_port_pkg::*;
	logic        mclk_i = 0, resetn_i = 0, strap = 1, arb_en = 1, rd_pend = 0;
	pbus_req_t   req;                          // Bus request
	logic [31:0] rdata, expq[$];               // Read data and expected reads
	logic [2:0]  arb_g, rpin, gpin, goe, rout, roe, rpu, own, ext_oe, ext_val;
	int          failures = 0, compares = 0, cycles = 0;
	// Device and far-side lines
	arbitration_pin_port DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .host_mode_pin_i(strap),
		.arb_enable_i(arb_en), .pbus_req_i(req), .pbus_rdata_o(rdata), .arb_grant_i(arb_g),
		.request_pin_i(rpin), .grant_pin_o(gpin), .grant_pin_oe_o(goe), .request_pin_o(rout),
		.request_pin_oe_o(roe), .request_pullup_o(rpu), .port_owned_o(own));
	req_pin_partner #(.PAIRS(3)) far (.mclk_i(mclk_i), .dev_out_i(rout), .dev_oe_i(roe),
		.pullup_i(rpu), .ext_oe_i(ext_oe), .ext_val_i(ext_val), .wire_o(rpin));
	// Clock at 40 MHz
	initial
	begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One bus access; strobe stays up so back-to-back accesses never glitch it
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		req = '{1'b1, wr, a, d};
		if (!wr)
			expq.push_back(exp);
		@(negedge mclk_i);
	endtask : bus
	// Drop the strobe and let one edge pass
	task automatic idle();
		req.sel = 1'b0;
		@(negedge mclk_i);
	endtask : idle
	// Pin levels and data read-back for control c and data d
	task automatic pins(input logic [31:0] c, input logic [31:0] d, input logic own_ok);
		logic [2:0]  en, dir;
		logic [31:0] exp;
		en = c[18:16] & {3{own_ok}};
		dir = en & {c[4], c[2], c[0]};
		idle();
		@(negedge mclk_i);
		check(32'(own), 32'(en));
		check(32'(goe), 32'(en));
		check(32'(gpin), 32'((en & {d[5], d[3], d[1]}) | (~en & arb_g)));
		check(32'(roe), 32'(dir));
		check(32'(rpu), 32'(en & ~{c[5], c[3], c[1]}));
		check(32'(rout & dir), 32'(dir & {d[4], d[2], d[0]}));
		exp = {26'h0, d[5:0]};
		for (int g = 0; g < 3; g++)
			if (en[g] && !dir[g])
				exp[2*g] = ext_val[g];
		bus(1'b0, 8'h04, 32'h0, exp);
	endtask : pins
	// Report counts and end the run
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// Take the oldest expected read when read data appears
	always @(posedge mclk_i)
	begin
		rd_pend <= req.sel & ~req.wr;
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			give_verdict();
		end
	end
	always @(negedge mclk_i)
	begin
		if (rd_pend && expq.size() > 0)
			check(rdata, expq.pop_front());
	end
	// Main sequence
	initial
	begin
		logic [31:0] c, d;
		void'($urandom(69237));
		req = '0;
		arb_g = 3'h5;
		ext_oe = 3'h0;
		ext_val = 3'h0;
		repeat (6) @(negedge mclk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		bus(1'b0, 8'h00, 32'h0, 32'h0);
		bus(1'b0, 8'h04, 32'h0, 32'h0);
		bus(1'b1, 8'h00, 32'hffffffff, 32'h0);
		bus(1'b1, 8'h04, 32'hffffffff, 32'h0);
		bus(1'b0, 8'h00, 32'h0, 32'h0007003f);
		bus(1'b0, 8'h08, 32'h0, 32'h0);
		pins(32'h0007003f, 32'h3f, 1'b1);
		ext_oe = 3'h7;
		for (int i = 0; i < 8; i++)
		begin
			c = $urandom() & 32'h0007003f;
			d = $urandom() & 32'h3f;
			ext_val = 3'($urandom());
			arb_g = 3'($urandom());
			bus(1'b1, 8'h00, c, 32'h0);
			bus(1'b1, 8'h04, d, 32'h0);
			pins(c, d, 1'b1);
		end
		idle();
		resetn_i = 1'b0;
		strap = 1'b0;
		repeat (2) @(negedge mclk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		strap = 1'b1;
		bus(1'b0, 8'h00, 32'h0, 32'h0);
		bus(1'b0, 8'h04, 32'h0, 32'h0);
		bus(1'b1, 8'h00, 32'h00070000, 32'h0);
		pins(32'h00070000, 32'h0, 1'b0);
		arb_en = 1'b0;
		pins(32'h00070000, 32'h0, 1'b1);
		idle();
		give_verdict();
	end
endmodule : test_arbitration_pin_port
`default_nettype wire
